/* File: pch_params.svh */
// Offsets, field positions, reset values and window span of the header tail
`ifndef PCH_PARAMS_SVH
`define PCH_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, one aligned word each)
`define PCH_OFF_WINDOW_BASE   8'h10
`define PCH_OFF_SUBSYS        8'h2c
`define PCH_OFF_INTR_GRANT    8'h3c
`define PCH_OFF_MASTER_LIMITS 8'h40
`define PCH_OFF_USER_WORD     8'h44

// ==========================================================
// Field positions
`define PCH_BASE_BIT          31
`define PCH_IRQ_LINE_LSB      0
`define PCH_IRQ_PIN_LSB       8
`define PCH_MIN_GRANT_LSB     16
`define PCH_MAX_LAT_LSB       24
`define PCH_TRDY_LSB          0
`define PCH_RETRY_LSB         8

// ==========================================================
// Reset values
`define PCH_RST_BASE          1'h0
`define PCH_RST_IRQ_LINE      8'h00
`define PCH_RST_IRQ_PIN       8'h01
`define PCH_RST_MIN_GRANT     8'h00
`define PCH_RST_MAX_LAT       8'h00
`define PCH_RST_TRDY_WAIT     8'h80
`define PCH_RST_RETRY         8'h80
`define PCH_RST_SUBSYS        16'h0000
`define PCH_RST_USER          32'h00000000

// ==========================================================
// Target window span above the base
`define PCH_WINDOW_SPAN       32'h03ff0000

`endif

/* File: pch_pkg.sv */
// Types shared by the configuration header tail
package pch_pkg;

	// ======================================================
	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pch_bus_req_t;

	// ======================================================
	// Values loaded from the serial configuration memory
	typedef struct packed {
		logic [15:0] sub_vendor;
		logic [15:0] sub_id;
		logic [31:0] user;
	} pch_eeprom_load_t;

	// ======================================================
	// Master transaction states
	typedef enum logic [3:0] {
		PCH_IDLE  = 4'b0001,
		PCH_WAIT  = 4'b0010,
		PCH_RETRY = 4'b0100,
		PCH_DONE  = 4'b1000
	} pch_mst_state_t;

endpackage : pch_pkg

/* File: pch_config_tail.sv */
// Configuration header tail: window base, subsystem codes, master limits
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "pch_params.svh"
`default_nettype none

module pch_config_tail (
	// Clock and reset
	input  wire logic                      CLOCK,
	input  wire logic                      NRST,
	// Register port
	input  wire pch_pkg::pch_bus_req_t     BUS_REQ,
	output logic [31:0]                    BUS_RDATA,
	// Configuration memory load
	input  wire logic                      LOAD_VALID,
	input  wire pch_pkg::pch_eeprom_load_t LOAD_DATA,
	// Target address decode
	input  wire logic                      TGT_MEM_CYCLE,
	input  wire logic [31:0]               TGT_ADDR,
	output logic                           TGT_CLAIM,
	// Bus master transaction tracking
	input  wire logic                      MST_START,
	input  wire logic                      MST_TRDY,
	input  wire logic                      MST_RETRY,
	output logic                           MST_BUSY,
	output logic                           MST_DONE_OK,
	output logic                           MST_FAIL_TRDY,
	output logic                           MST_FAIL_RETRY
);
	import pch_pkg::*;

	// ======================================================
	// Register state
	logic        base_reg, base_next;
	logic [7:0]  irq_line_reg, irq_line_next;
	logic [7:0]  irq_pin_reg, irq_pin_next;
	logic [7:0]  trdy_lim_reg, trdy_lim_next;
	logic [7:0]  retry_lim_reg, retry_lim_next;
	logic [15:0] sub_vendor_reg, sub_vendor_next;
	logic [15:0] sub_id_reg, sub_id_next;
	logic [31:0] user_reg, user_next;
	logic [31:0] rdata_reg, rdata_next;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	always_comb begin
		base_next      = base_reg;
		irq_line_next  = irq_line_reg;
		irq_pin_next   = irq_pin_reg;
		trdy_lim_next  = trdy_lim_reg;
		retry_lim_next = retry_lim_reg;
		sub_vendor_next = sub_vendor_reg;
		sub_id_next    = sub_id_reg;
		user_next      = user_reg;
		rdata_next     = 32'h00000000;
		// Loaded values only, host writes never reach these
		if (LOAD_VALID) begin
			sub_vendor_next = LOAD_DATA.sub_vendor;
			sub_id_next     = LOAD_DATA.sub_id;
			user_next       = LOAD_DATA.user;
		end
		if (BUS_REQ.wr) begin
			if (hit(BUS_REQ.addr, `PCH_OFF_WINDOW_BASE)) begin
				base_next = BUS_REQ.wdata[`PCH_BASE_BIT];
			end
			if (hit(BUS_REQ.addr, `PCH_OFF_INTR_GRANT)) begin
				irq_line_next = BUS_REQ.wdata[`PCH_IRQ_LINE_LSB +: 8];
				irq_pin_next  = BUS_REQ.wdata[`PCH_IRQ_PIN_LSB +: 8];
			end
			if (hit(BUS_REQ.addr, `PCH_OFF_MASTER_LIMITS)) begin
				trdy_lim_next  = BUS_REQ.wdata[`PCH_TRDY_LSB +: 8];
				retry_lim_next = BUS_REQ.wdata[`PCH_RETRY_LSB +: 8];
			end
		end
		if (BUS_REQ.rd) begin
			case (BUS_REQ.addr)
				`PCH_OFF_WINDOW_BASE: begin
					rdata_next[`PCH_BASE_BIT] = base_reg;
				end
				`PCH_OFF_SUBSYS: begin
					rdata_next = {sub_id_reg, sub_vendor_reg};
				end
				`PCH_OFF_INTR_GRANT: begin
					rdata_next[`PCH_IRQ_LINE_LSB +: 8]  = irq_line_reg;
					rdata_next[`PCH_IRQ_PIN_LSB +: 8]   = irq_pin_reg;
					rdata_next[`PCH_MIN_GRANT_LSB +: 8] = `PCH_RST_MIN_GRANT;
					rdata_next[`PCH_MAX_LAT_LSB +: 8]   = `PCH_RST_MAX_LAT;
				end
				`PCH_OFF_MASTER_LIMITS: begin
					rdata_next[`PCH_TRDY_LSB +: 8]  = trdy_lim_reg;
					rdata_next[`PCH_RETRY_LSB +: 8] = retry_lim_reg;
				end
				`PCH_OFF_USER_WORD: begin
					rdata_next = user_reg;
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			base_reg       <= `PCH_RST_BASE;
			irq_line_reg   <= `PCH_RST_IRQ_LINE;
			irq_pin_reg    <= `PCH_RST_IRQ_PIN;
			trdy_lim_reg   <= `PCH_RST_TRDY_WAIT;
			retry_lim_reg  <= `PCH_RST_RETRY;
			sub_vendor_reg <= `PCH_RST_SUBSYS;
			sub_id_reg     <= `PCH_RST_SUBSYS;
			user_reg       <= `PCH_RST_USER;
			rdata_reg      <= 32'h00000000;
		end else begin
			base_reg       <= base_next;
			irq_line_reg   <= irq_line_next;
			irq_pin_reg    <= irq_pin_next;
			trdy_lim_reg   <= trdy_lim_next;
			retry_lim_reg  <= retry_lim_next;
			sub_vendor_reg <= sub_vendor_next;
			sub_id_reg     <= sub_id_next;
			user_reg       <= user_next;
			rdata_reg      <= rdata_next;
		end
	end

	assign BUS_RDATA = rdata_reg;

	// ======================================================
	// Target window decode
	logic [32:0] win_lo;
	logic [32:0] win_hi;
	logic        claim_reg, claim_next;

	assign win_lo = {1'b0, base_reg, 31'h00000000};
	assign win_hi = win_lo + {1'b0, `PCH_WINDOW_SPAN};

	always_comb begin
		claim_next = TGT_MEM_CYCLE &&
			({1'b0, TGT_ADDR} >= win_lo) &&
			({1'b0, TGT_ADDR} <= win_hi);
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			claim_reg <= 1'b0;
		end else begin
			claim_reg <= claim_next;
		end
	end

	assign TGT_CLAIM = claim_reg;

	// ======================================================
	// Master wait and retry limits
	pch_mst_state_t state_reg, state_next;
	logic [7:0]     wait_cnt_reg, wait_cnt_next;
	logic [7:0]     retry_cnt_reg, retry_cnt_next;
	logic           ok_reg, ok_next;
	logic           ftrdy_reg, ftrdy_next;
	logic           fretry_reg, fretry_next;

	always_comb begin
		state_next     = state_reg;
		wait_cnt_next  = wait_cnt_reg;
		retry_cnt_next = retry_cnt_reg;
		ok_next        = 1'b0;
		ftrdy_next     = 1'b0;
		fretry_next    = 1'b0;
		case (state_reg)
			PCH_IDLE: begin
				if (MST_START) begin
					state_next     = PCH_WAIT;
					wait_cnt_next  = 8'h00;
					retry_cnt_next = 8'h00;
				end
			end
			PCH_WAIT: begin
				if (MST_TRDY) begin
					ok_next    = 1'b1;
					state_next = PCH_DONE;
				end else if (MST_RETRY) begin
					state_next = PCH_RETRY;
				end else if (wait_cnt_reg + 8'h01 >= trdy_lim_reg) begin
					ftrdy_next = 1'b1;
					state_next = PCH_DONE;
				end else begin
					wait_cnt_next = wait_cnt_reg + 8'h01;
				end
			end
			PCH_RETRY: begin
				if (retry_cnt_reg >= retry_lim_reg) begin
					fretry_next = 1'b1;
					state_next  = PCH_DONE;
				end else begin
					retry_cnt_next = retry_cnt_reg + 8'h01;
					wait_cnt_next  = 8'h00;
					state_next     = PCH_WAIT;
				end
			end
			PCH_DONE: begin
				state_next = PCH_IDLE;
			end
			default: begin
				state_next = PCH_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state_reg     <= PCH_IDLE;
			wait_cnt_reg  <= 8'h00;
			retry_cnt_reg <= 8'h00;
			ok_reg        <= 1'b0;
			ftrdy_reg     <= 1'b0;
			fretry_reg    <= 1'b0;
		end else begin
			state_reg     <= state_next;
			wait_cnt_reg  <= wait_cnt_next;
			retry_cnt_reg <= retry_cnt_next;
			ok_reg        <= ok_next;
			ftrdy_reg     <= ftrdy_next;
			fretry_reg    <= fretry_next;
		end
	end

	assign MST_BUSY       = (state_reg != PCH_IDLE);
	assign MST_DONE_OK    = ok_reg;
	assign MST_FAIL_TRDY  = ftrdy_reg;
	assign MST_FAIL_RETRY = fretry_reg;

endmodule : pch_config_tail
`default_nettype wire

/* File: pch_tail_assertions.sv */
// Port-level checks of the configuration header tail
`timescale 1ns/1ps
`default_nettype none
module pch_tail_assertions (
	// Clock and reset
	input wire logic                      CLOCK,
	input wire logic                      NRST,
	// Register port
	input wire pch_pkg::pch_bus_req_t     BUS_REQ,
	input wire logic [31:0]               BUS_RDATA,
	// Load, target, master
	input wire logic                      LOAD_VALID,
	input wire pch_pkg::pch_eeprom_load_t LOAD_DATA,
	input wire logic                      TGT_MEM_CYCLE,
	input wire logic [31:0]               TGT_ADDR,
	input wire logic                      TGT_CLAIM,
	input wire logic                      MST_START,
	input wire logic                      MST_TRDY,
	input wire logic                      MST_RETRY,
	input wire logic                      MST_BUSY,
	input wire logic                      MST_DONE_OK,
	input wire logic                      MST_FAIL_TRDY,
	input wire logic                      MST_FAIL_RETRY
);
	import pch_pkg::*;
	logic base_reg, base_next, hit_reg, hit_next;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// Shadow of the window base and expected claim
	always_comb begin
		base_next = base_reg;
		if (BUS_REQ.wr && BUS_REQ.addr == 8'h10)
			base_next = BUS_REQ.wdata[31];
		hit_next = TGT_MEM_CYCLE && TGT_ADDR[31] == base_reg
			&& TGT_ADDR[30:0] <= 31'h03ff0000;
	end
	always_ff @(posedge CLOCK) begin
		base_reg <= NRST && base_next;
		hit_reg  <= NRST && hit_next;
	end
	sequence s_rd(logic [7:0] a);
		BUS_REQ.rd && BUS_REQ.addr == a;
	endsequence
	sequence s_end;
		MST_BUSY ##1 !MST_BUSY;
	endsequence
	AST_BASE_LOW:
	assert property (s_rd(8'h10) |=> BUS_RDATA[30:0] == 31'h0)
		else $error("base low bits set");
	AST_GRANT_ZERO:
	assert property (s_rd(8'h3c) |=> BUS_RDATA[31:16] == 16'h0)
		else $error("grant or latency not zero");
	AST_CLAIM:
	assert property (TGT_CLAIM == hit_reg)
		else $error("claim wrong");
	AST_START_BUSY:
	assert property (!MST_BUSY && MST_START |=> MST_BUSY)
		else $error("start not taken");
	AST_DONE_CAUSE:
	assert property (MST_DONE_OK |-> $past(MST_TRDY))
		else $error("done without ready");
	AST_FAIL_TRDY:
	assert property (MST_FAIL_TRDY |-> !$past(MST_TRDY) && $past(MST_BUSY))
		else $error("timeout without wait");
	AST_ONE_RESULT:
	assert property ($onehot0({MST_DONE_OK, MST_FAIL_TRDY, MST_FAIL_RETRY}))
		else $error("two results");
	AST_END:
	assert property (MST_DONE_OK || MST_FAIL_TRDY || MST_FAIL_RETRY |-> s_end)
		else $error("no return to idle");
endmodule : pch_tail_assertions
bind pch_config_tail pch_tail_assertions u_chk (.CLOCK, .NRST, .BUS_REQ,
	.BUS_RDATA, .LOAD_VALID, .LOAD_DATA, .TGT_MEM_CYCLE, .TGT_ADDR,
	.TGT_CLAIM, .MST_START, .MST_TRDY, .MST_RETRY, .MST_BUSY,
	.MST_DONE_OK, .MST_FAIL_TRDY, .MST_FAIL_RETRY);
`default_nettype wire

/* File: pch_target_model.sv */
// Far-side target answering the block's master transactions
`timescale 1ns/1ps
`default_nettype none
module pch_target_model (
	// Clock and transaction state
	input  wire logic       clock,
	input  wire logic       busy,
	// Mode 0 ready after delay, 1 retry, 2 silent
	input  wire logic [1:0] mode,
	input  wire logic [3:0] delay,
	// Answers
	output logic            trdy,
	output logic            retry
);
	logic [3:0] wait_reg;
	always_ff @(posedge clock) begin
		wait_reg <= busy ? wait_reg + 4'h1 : 4'h0;
	end
	assign trdy  = busy && mode == 2'h0 && wait_reg >= delay;
	assign retry = busy && mode == 2'h1;
endmodule : pch_target_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the configuration header tail
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pch_pkg::*;
	logic CLOCK, NRST, LOAD_VALID, TGT_MEM_CYCLE, TGT_CLAIM, MST_START;
	logic MST_TRDY, MST_RETRY, MST_BUSY;
	logic MST_DONE_OK, MST_FAIL_TRDY, MST_FAIL_RETRY;
	logic [31:0] BUS_RDATA, TGT_ADDR;
	logic [1:0] mode;
	logic [3:0] delay;
	pch_bus_req_t BUS_REQ;
	pch_eeprom_load_t LOAD_DATA;
	int fail_count, checks;
	pch_config_tail dut (.CLOCK, .NRST, .BUS_REQ, .BUS_RDATA, .LOAD_VALID,
		.LOAD_DATA, .TGT_MEM_CYCLE, .TGT_ADDR, .TGT_CLAIM, .MST_START,
		.MST_TRDY, .MST_RETRY, .MST_BUSY, .MST_DONE_OK, .MST_FAIL_TRDY,
		.MST_FAIL_RETRY);
	pch_target_model far (.clock(CLOCK), .busy(MST_BUSY), .mode, .delay,
		.trdy(MST_TRDY), .retry(MST_RETRY));
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		BUS_REQ <= '{a, d, 1'b1, 1'b0};
		@(posedge CLOCK);
		BUS_REQ <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLOCK);
		BUS_REQ <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge CLOCK);
		BUS_REQ <= '0;
		#1 cmp(BUS_RDATA, e);
	endtask : rd
	task automatic probe(input logic [31:0] a, input logic e);
		@(posedge CLOCK);
		TGT_MEM_CYCLE <= 1'b1;
		TGT_ADDR <= a;
		@(posedge CLOCK);
		TGT_MEM_CYCLE <= 1'b0;
		#1 cmp({31'h0, TGT_CLAIM}, {31'h0, e});
	endtask : probe
	task automatic mst(input logic [1:0] m, input logic [3:0] dl,
		input logic [2:0] e, input int n);
		int k;
		k = 0;
		@(posedge CLOCK);
		mode <= m;
		delay <= dl;
		MST_START <= 1'b1;
		@(posedge CLOCK);
		MST_START <= 1'b0;
		do begin
			@(posedge CLOCK);
			#1 k++;
		end while (k < 40
			&& {MST_DONE_OK, MST_FAIL_TRDY, MST_FAIL_RETRY} === 3'h0);
		cmp({29'h0, MST_DONE_OK, MST_FAIL_TRDY, MST_FAIL_RETRY}, {29'h0, e});
		if (n > 0) cmp(k, n);
		@(posedge CLOCK);
		#1 cmp({31'h0, MST_BUSY}, 32'h0);
	endtask : mst
	task automatic t_reset();
		rd(8'h10, 32'h0);
		rd(8'h2c, 32'h0);
		rd(8'h3c, 32'h00000100);
		rd(8'h40, 32'h00008080);
		rd(8'h44, 32'h0);
	endtask : t_reset
	task automatic t_regs();
		wr(8'h10, 32'hffffffff);
		rd(8'h10, 32'h80000000);
		wr(8'h3c, 32'h0000025a);
		rd(8'h3c, 32'h0000025a);
		wr(8'h40, 32'h00000203);
		rd(8'h40, 32'h00000203);
		wr(8'h2c, 32'hffffffff);
		wr(8'h44, 32'hffffffff);
		wr(8'h20, 32'hffffffff);
		rd(8'h2c, 32'h0);
		rd(8'h44, 32'h0);
		rd(8'h20, 32'h0);
		@(posedge CLOCK);
		LOAD_VALID <= 1'b1;
		LOAD_DATA <= '{16'h1357, 16'h2468, 32'hcafe0011};
		@(posedge CLOCK);
		LOAD_VALID <= 1'b0;
		rd(8'h2c, 32'h24681357);
		rd(8'h44, 32'hcafe0011);
	endtask : t_regs
	task automatic t_claim();
		probe(32'h80000000, 1'b1);
		probe(32'h83ff0000, 1'b1);
		probe(32'h83ff0001, 1'b0);
		probe(32'h7fffffff, 1'b0);
		wr(8'h10, 32'h0);
		probe(32'h03ff0000, 1'b1);
		probe(32'h83ff0000, 1'b0);
	endtask : t_claim
	task automatic t_master();
		mst(2'h0, 4'h0, 3'h4, 1);
		mst(2'h0, 4'h1, 3'h4, 2);
		mst(2'h2, 4'h0, 3'h2, 3);
		mst(2'h1, 4'h0, 3'h1, 0);
	endtask : t_master
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	initial begin
		#50000;
		fail_count++;
		stop_test();
	end
	initial begin
		NRST = 1'b0;
		BUS_REQ = '0;
		LOAD_VALID = 1'b0;
		LOAD_DATA = '0;
		TGT_MEM_CYCLE = 1'b0;
		TGT_ADDR = '0;
		MST_START = 1'b0;
		mode = 2'h2;
		delay = 4'h0;
		fail_count = 0;
		checks = 0;
		repeat (2) @(posedge CLOCK);
		NRST <= 1'b1;
		t_reset();
		t_regs();
		t_claim();
		t_master();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
